// ---- prpo_regs.svh ----
// Constants for the power-up reset, preload and observe block
`ifndef PRPO_REGS_SVH
`define PRPO_REGS_SVH
`define PRPO_NUM_REGS     8
`define PRPO_REG_RESET    1'b0
`define PRPO_PWRUP_TIME_US 10
`define PRPO_CLK_MHZ      125
`define PRPO_PWRUP_CYCLES (`PRPO_PWRUP_TIME_US * `PRPO_CLK_MHZ)
`endif

// ---- prpo_pkg.sv ----
// Types for the power-up reset, preload and observe block
package prpo_pkg;
  typedef enum logic [1:0] {
    PRPO_NORMAL  = 2'b00,
    PRPO_PRELOAD = 2'b01,
    PRPO_OBSERVE = 2'b10
  } prpo_mode_type;
endpackage

// ---- prpo_core.sv ----
// Register array with power-up clear, preload and observe test modes
`timescale 1ns/1ps
`include "prpo_regs.svh"
module prpo_core #(
  parameter int N          = `PRPO_NUM_REGS,
  parameter int PWRUP_CYC  = `PRPO_PWRUP_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic [1:0]   test_mode,
  input  wire logic [N-1:0] d_in,
  input  wire logic [N-1:0] comb_in,
  input  wire logic [N-1:0] comb_sel,
  input  wire logic [N-1:0] polarity,
  input  wire logic [N-1:0] normal_oe,
  input  wire logic [N-1:0] async_clr,
  input  wire logic [N-1:0] async_set,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] pin_out,
  output logic      [N-1:0] pin_oe,
  output logic              pwrup_busy
);

  // Decoded mode
  prpo_pkg::prpo_mode_type mode;
  logic                    preload_act;
  logic                    observe_act;
  logic                    test_act;
  logic                    normal_act;

  // Power-up clear window
  logic [13:0]             pu_cnt_reg;
  logic [13:0]             pu_cnt_next;
  logic                    pu_busy;

  // Register array
  logic [N-1:0]            q_reg;
  logic [N-1:0]            q_next;
  logic [N-1:0]            q_load;
  logic [N-1:0]            q_forced;

  // Output cells and pin drivers
  wire  [N-1:0]            norm_val;
  wire  [N-1:0]            norm_oe;
  wire  [N-1:0]            test_val;
  wire  [N-1:0]            test_oe;
  logic [N-1:0]            out_reg;
  logic [N-1:0]            out_next;
  logic [N-1:0]            oe_reg;
  logic [N-1:0]            oe_next;

  // Code 11 is spare and falls back to normal, so a stray code is harmless
  always_comb begin
    case (test_mode)
      2'b00: begin
        mode = prpo_pkg::PRPO_NORMAL;
      end
      2'b01: begin
        mode = prpo_pkg::PRPO_PRELOAD;
      end
      2'b10: begin
        mode = prpo_pkg::PRPO_OBSERVE;
      end
      default: begin
        mode = prpo_pkg::PRPO_NORMAL;
      end
    endcase
  end

  // One-hot test flags
  always_comb begin
    preload_act = 1'b0;
    observe_act = 1'b0;
    case (mode)
      prpo_pkg::PRPO_PRELOAD: begin
        preload_act = 1'b1;
      end
      prpo_pkg::PRPO_OBSERVE: begin
        observe_act = 1'b1;
      end
      default: begin
        preload_act = 1'b0;
      end
    endcase
  end

  assign test_act   = preload_act | observe_act;
  assign normal_act = ~test_act;

  // Reset stands in for the power-on event; no other clear is needed
  // Limitation: a 14-bit counter, so the window must stay below 16384
  always_comb begin
    pu_cnt_next = pu_cnt_reg;
    if (pu_busy) begin
      pu_cnt_next = pu_cnt_reg - 14'h0001;
    end else begin
      pu_cnt_next = 14'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pu_cnt_reg <= 14'(PWRUP_CYC);
    end else if (clk_en) begin
      pu_cnt_reg <= pu_cnt_next;
    end
  end

  assign pu_busy    = (pu_cnt_reg != 14'h0000);
  assign pwrup_busy = pu_busy;

  // Preload takes the pins; observe loads back q_reg; normal takes d_in
  always_comb begin
    q_load = q_reg;
    if (preload_act) begin
      q_load = pin_in;
    end else if (normal_act) begin
      q_load = d_in;
    end else begin
      q_load = q_reg;
    end
  end

  // Async lines act after the load, so they can overwrite preloaded data
  always_comb begin
    q_forced = q_load;
    q_forced = q_forced & ~async_clr;
    q_forced = q_forced | async_set;
  end

  // The clear window beats every other source, async lines included
  always_comb begin
    q_next = q_forced;
    if (pu_busy) begin
      q_next = {N{`PRPO_REG_RESET}};
    end
  end

  // Clock enable low freezes the array, test modes included
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_reg <= {N{`PRPO_REG_RESET}};
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  // One output cell per register; polarity only acts in normal mode
  for (genvar i = 0; i < N; i++) begin : g_cell
    logic cell_term;
    logic cell_path;
    logic cell_norm;

    // Product terms gated off in test modes, so no comb data leaks out
    always_comb begin
      cell_term = comb_in[i] & normal_act;
      cell_path = q_next[i];
      if (comb_sel[i]) begin
        cell_path = cell_term;
      end
      cell_norm = cell_path ^ polarity[i];
    end

    assign norm_val[i] = cell_norm;
    assign norm_oe[i]  = normal_oe[i];
    // Test modes show the stored value without polarity
    assign test_val[i] = q_next[i];
    assign test_oe[i]  = observe_act;
  end

  // Stateless normal path, so the normal value returns on leaving test
  always_comb begin
    out_next = out_reg;
    if (test_act) begin
      out_next = test_val;
    end else begin
      out_next = norm_val;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_reg <= '0;
    end else if (clk_en) begin
      out_reg <= out_next;
    end
  end

  // Preload keeps drivers off so the pins act as inputs
  always_comb begin
    oe_next = oe_reg;
    if (test_act) begin
      oe_next = test_oe;
    end else begin
      oe_next = norm_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oe_reg <= '0;
    end else if (clk_en) begin
      oe_reg <= oe_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe  = oe_reg;
endmodule

// ---- prpo_core_props.sv ----
// Checker for the preload and observe block
`timescale 1ns/1ps
module prpo_core_props #(
  parameter int N = 8
) (
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic         clk_en,
  input wire logic         pwrup_busy,
  input wire logic [1:0]   test_mode,
  input wire logic [N-1:0] normal_oe,
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] async_clr,
  input wire logic [N-1:0] async_set
);
  default clocking @(posedge clk); endclocking
  wire g = clk_en && !pwrup_busy && !(|{async_clr, async_set});
  AST_CLEAR: assert property (sys_rst |=>
    pwrup_busy && pin_oe == '0 && pin_out == '0) else $error("clear");
  AST_BUSY_HOLD: assert property (disable iff (sys_rst)
    clk_en && pwrup_busy && test_mode == 2'h1 |=> pin_out == '0)
    else $error("busy clear");
  AST_FREEZE: assert property (disable iff (sys_rst)
    !clk_en |=> $stable(pin_out) && $stable(pin_oe)) else $error("freeze");
  AST_NORMAL_OE: assert property (disable iff (sys_rst)
    clk_en && (test_mode == 2'h0 || test_mode == 2'h3)
    |=> pin_oe == $past(normal_oe)) else $error("normal enable");
  AST_ASYNC: assert property (disable iff (sys_rst)
    clk_en && !pwrup_busy && test_mode == 2'h1
    |=> (pin_out & $past(async_set)) == $past(async_set))
    else $error("async set");
  AST_PRELOAD: assert property (disable iff (sys_rst)
    g && test_mode == 2'h1 |=> pin_out == $past(pin_in)) else $error("load");
  AST_OBSERVE: assert property (disable iff (sys_rst)
    g && test_mode == 2'h2 |=> &pin_oe) else $error("observe");
  cover property (g && test_mode == 2'h0);
  cover property (g && test_mode == 2'h1);
  cover property (g && test_mode == 2'h2);
endmodule
bind prpo_core prpo_core_props #(.N(N)) props (
  .clk        (clk),
  .sys_rst    (sys_rst),
  .clk_en     (clk_en),
  .pwrup_busy (pwrup_busy),
  .test_mode  (test_mode),
  .normal_oe  (normal_oe),
  .pin_in     (pin_in),
  .pin_out    (pin_out),
  .pin_oe     (pin_oe),
  .async_clr  (async_clr),
  .async_set  (async_set)
);

// ---- prpo_tester.sv ----
// Tester model driving the I/O pins
`timescale 1ns/1ps
module prpo_tester (
  input wire logic       clk,
  input wire logic [7:0] pin_out, pin_oe,
  output logic     [7:0] pin_in
);
  logic [7:0] drv = 8'h00;
  // Drives only on the falling edge, so setup holds before each rising edge
  always @(negedge clk) drv <= 8'($urandom);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
endmodule

// ---- prpo_core_test.sv ----
// Self-checking bench for the preload and observe block
`timescale 1ns/1ps
module prpo_core_test;
  localparam int PU = 4;
  logic        clk = 0, sys_rst = 1, clk_en = 1, pwrup_busy;
  logic [1:0]  test_mode = 0;
  logic [7:0]  d_in = 0, comb_in = 0, polarity = 0, pin_in, pin_out, pin_oe;
  logic [7:0]  comb_sel = 8'hFF, normal_oe = 8'h0F;
  logic [7:0]  async_clr = 8'h00, async_set = 8'h00;
  logic [7:0]  exp_q = 8'h00, exp_out = 8'h00, exp_oe = 8'h00, qn;
  logic [16:0] notes[$];
  logic [16:0] seen;
  int          miscompares = 0, samples_checked = 0, cycles = 0;
  int          pu_left = PU;
  initial forever #4 clk = ~clk;
  prpo_core #(.N(8), .PWRUP_CYC(PU)) dut (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .test_mode  (test_mode),
    .d_in       (d_in),
    .comb_in    (comb_in),
    .comb_sel   (comb_sel),
    .polarity   (polarity),
    .normal_oe  (normal_oe),
    .async_clr  (async_clr),
    .async_set  (async_set),
    .pin_in     (pin_in),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe),
    .pwrup_busy (pwrup_busy)
  );
  prpo_tester tester (
    .clk     (clk),
    .pin_out (pin_out),
    .pin_oe  (pin_oe),
    .pin_in  (pin_in)
  );
  // Reference model of one rising edge, from the rules alone
  task automatic model_edge;
    if (sys_rst) begin
      pu_left = PU;
      exp_q = 8'h00;
      exp_out = 8'h00;
      exp_oe = 8'h00;
    end else if (clk_en) begin
      qn = exp_q;
      if (test_mode == 2'h1) qn = pin_in;
      else if (test_mode != 2'h2) qn = d_in;
      qn = (qn & ~async_clr) | async_set;
      if (pu_left != 0) qn = 8'h00;
      if (test_mode == 2'h1 || test_mode == 2'h2) begin
        exp_out = qn;
        exp_oe = {8{test_mode == 2'h2}};
      end else begin
        exp_out = ((comb_sel & comb_in) | (~comb_sel & qn)) ^ polarity;
        exp_oe = normal_oe;
      end
      exp_q = qn;
      if (pu_left != 0) pu_left--;
    end
    notes.push_back({pu_left != 0, exp_oe, exp_out});
  endtask
  task automatic give_verdict;
    $display("checked %0d wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) if (++cycles > 1000) begin
    miscompares++;
    give_verdict;
  end
  always @(negedge clk) if (notes.size() > 0) begin
    seen = {pwrup_busy, pin_oe, pin_out};
    samples_checked++;
    if (seen !== notes[0]) begin
      $display("wrong value %0t %h %h", $time, seen, notes[0]);
      miscompares++;
    end
    void'(notes.pop_front());
  end
  initial begin
    void'($urandom(32'h7F7AA0C9));
    repeat (2) @(negedge clk);
    // Inputs settle with the clock low before each rising edge
    for (int i = 0; i < 400; i++) begin
      sys_rst = (i == 200);
      clk_en = ($urandom_range(7) != 0);
      {test_mode, d_in, comb_in, polarity} = 26'($urandom);
      comb_sel = 8'($urandom);
      normal_oe = 8'($urandom);
      async_clr = 8'($urandom) & 8'($urandom) & 8'($urandom);
      async_set = 8'($urandom) & 8'($urandom) & 8'($urandom);
      #2;
      model_edge();
      @(negedge clk);
    end
    #1;
    give_verdict;
  end
endmodule
